// File: mou_pkg.sv
/*
 * Shared types and constants of the memory ordering unit, and the
 * lowest-index picker that the unit uses to choose entries.
 * Assumes one clock domain; the picker is purely combinational.
 */
package mou_pkg;
	localparam int MOU_DEPTH = 8;
	localparam int MOU_TW = 3;
	localparam int MOU_AW = 32;

	typedef enum logic [2:0] {
		K_LOAD = 3'h0,
		K_STORE = 3'h1,
		K_ACQUIRE_LOAD = 3'h2,
		K_RELEASE_STORE = 3'h3,
		K_MEMORY_FENCE_OP = 3'h4
	} mou_kind_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_BUSY = 1'h1
	} mou_state_t;

	localparam mou_kind_t MOU_KIND_RST = K_LOAD;
	localparam logic [MOU_AW-1:0] MOU_ADDR_RST = 32'h0000_0000;

	typedef struct packed {
		mou_kind_t kind;
		logic [MOU_AW-1:0] addr;
		logic dep_valid;
		logic [MOU_TW-1:0] dep_tag;
	} mou_op_t;

	typedef struct packed {
		mou_kind_t kind;
		logic [MOU_AW-1:0] addr;
		logic [MOU_TW-1:0] tag;
	} mou_vis_t;

	localparam mou_vis_t MOU_VIS_RST = '{kind: K_LOAD, addr: 32'h0000_0000, tag: 3'h0};

	function automatic logic mou_is_write(input mou_kind_t k);
		return (k == K_STORE) || (k == K_RELEASE_STORE);
	endfunction

	function automatic logic mou_is_barrier(input mou_kind_t k);
		return (k == K_MEMORY_FENCE_OP) || (k == K_ACQUIRE_LOAD);
	endfunction

	function automatic logic mou_drains_older(input mou_kind_t k);
		return (k == K_MEMORY_FENCE_OP) || (k == K_RELEASE_STORE);
	endfunction
endpackage

`timescale 1ns/1ns
module mou_pick #(
	parameter int N = 8,
	parameter int TW = 3
) (
	input wire logic [N-1:0] i_req, // request vector
	output logic o_any, // some request set
	output logic [TW-1:0] o_idx // lowest set index
);
	always_comb begin
		o_any = |i_req;
		o_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_idx = TW'(i);
			end
		end
	end
endmodule

// File: mou_order_unit.sv
/*
 * Memory ordering unit: holds outstanding memory operations, grants
 * local completion in dependence order and global visibility in the
 * order that fences, acquires, releases and same-address writes need.
 * Assumes the issuing pipeline and the coherence port share i_sys_clk.
 */
// Functional notes
// - accesses before a fence go visible first; later ones wait for the fence
// - loads may pass earlier stores to other addresses unless fenced
// - same-address RAW, WAR, WAW resolve locally in program order
// - locally ordered operations may still go global in any order
// - same-address writes go global in program order
// - register producer completes locally before its consumer
// - dependence ordering is transitive, through predicates too
// - branch-carried dependence orders loads like predication does
// - acquire load goes global before every later operation
// - later ops may pass a release; earlier ops may trail an acquire
// - every operation is locally visible before it is globally visible
`timescale 1ns/1ns
module mou_order_unit
	import mou_pkg::*;
#(
	parameter int DEPTH = MOU_DEPTH
) (
	input wire logic i_sys_clk, // clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_ce, // clock enable
	input wire logic i_op_valid, // new operation offered
	input wire mou_op_t i_op, // new operation
	output logic o_op_ready, // a free entry exists
	output logic o_acc_valid, // pulse: operation accepted
	output logic [MOU_TW-1:0] o_acc_tag, // tag of accepted operation
	output logic o_loc_valid, // pulse: operation locally visible
	output mou_vis_t o_loc, // operation made locally visible
	output logic o_glob_valid, // global visibility request
	output mou_vis_t o_glob, // operation offered to coherence domain
	input wire logic i_glob_ready, // coherence domain accepts it
	output logic o_empty // nothing outstanding
);
	logic [DEPTH-1:0] vld_ff, nxt_vld;
	logic [DEPTH-1:0] lvis_ff, nxt_lvis;
	logic [DEPTH-1:0] iss_ff, nxt_iss;
	logic [DEPTH-1:0] dep_ff [DEPTH];
	logic [DEPTH-1:0] nxt_dep [DEPTH];
	logic [DEPTH-1:0] waw_ff [DEPTH];
	logic [DEPTH-1:0] nxt_waw [DEPTH];
	logic [DEPTH-1:0] old_ff [DEPTH];
	logic [DEPTH-1:0] nxt_old [DEPTH];
	mou_kind_t kind_ff [DEPTH];
	logic [MOU_AW-1:0] addr_ff [DEPTH];
	mou_state_t state_ff;
	mou_vis_t glob_ff, loc_ff;
	logic loc_valid_ff, acc_valid_ff;
	logic [MOU_TW-1:0] acc_tag_ff;

	logic [DEPTH-1:0] bar_vec, loc_req, glob_req, same_vec, waw_vec;
	logic [DEPTH-1:0] free_vec, live, chain_vec, new_dep, dep_one;
	logic [DEPTH-1:0] hold [DEPTH];
	logic a_any, l_any, g_any, take, loc_take, issue, free_ev;
	logic [MOU_TW-1:0] a_idx, l_idx, g_idx;

	assign free_ev = i_ce && (state_ff == ST_BUSY) && i_glob_ready;
	assign free_vec = free_ev ? (DEPTH'(1) << glob_ff.tag) : '0;
	assign live = vld_ff & ~free_vec;
	assign o_op_ready = ~&vld_ff;
	assign take = i_ce && i_op_valid && a_any;
	assign loc_take = i_ce && l_any;
	assign issue = i_ce && (state_ff == ST_IDLE) && g_any;

	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		// releases are not barriers: later operations may pass them
		assign bar_vec[i] = vld_ff[i] && mou_is_barrier(kind_ff[i]);
		// wait until every producer and same-address predecessor is local
		assign loc_req[i] = vld_ff[i] && !lvis_ff[i] &&
			((dep_ff[i] & vld_ff & ~lvis_ff) == '0);
		// fences and releases drain all older; otherwise only barriers and WAW
		assign hold[i] = mou_drains_older(kind_ff[i]) ? '1 : (bar_vec | waw_ff[i]);
		// register deps and plain stores outside WAW are not in hold: free global order
		assign glob_req[i] = vld_ff[i] && lvis_ff[i] && !iss_ff[i] &&
			((old_ff[i] & vld_ff & hold[i]) == '0);
		assign same_vec[i] = live[i] && (addr_ff[i] == i_op.addr) &&
			(mou_is_write(kind_ff[i]) || mou_is_write(i_op.kind));
		assign waw_vec[i] = live[i] && (addr_ff[i] == i_op.addr) &&
			mou_is_write(kind_ff[i]) && mou_is_write(i_op.kind);
	end

	assign dep_one = DEPTH'(1) << i_op.dep_tag;
	// producer plus its own chain: compare/predicate/branch links stay transitive
	assign chain_vec = (i_op.dep_valid && live[i_op.dep_tag]) ?
		((dep_ff[i_op.dep_tag] | dep_one) & live) : '0;
	// a new op also waits locally on older live fences and acquires
	assign new_dep = (mou_drains_older(i_op.kind) ? live : '0) | same_vec |
		(bar_vec & live) | chain_vec;

	mou_pick #(.N(DEPTH), .TW(MOU_TW)) u_alloc_pick (
		.i_req(~vld_ff),
		.o_any(a_any),
		.o_idx(a_idx)
	);

	mou_pick #(.N(DEPTH), .TW(MOU_TW)) u_glob_pick (
		.i_req(glob_req),
		.o_any(g_any),
		.o_idx(g_idx)
	);

	mou_pick #(.N(DEPTH), .TW(MOU_TW)) u_loc_pick (
		.i_req(loc_req),
		.o_any(l_any),
		.o_idx(l_idx)
	);

	always_comb begin
		nxt_vld = vld_ff;
		nxt_lvis = lvis_ff;
		nxt_iss = iss_ff;
		for (int i = 0; i < DEPTH; i++) begin
			nxt_dep[i] = dep_ff[i] & ~free_vec;
			nxt_waw[i] = waw_ff[i] & ~free_vec;
			nxt_old[i] = old_ff[i] & ~free_vec;
		end
		if (free_ev) begin
			nxt_vld[glob_ff.tag] = 1'b0;
		end
		if (issue) begin
			nxt_iss[g_idx] = 1'b1;
		end
		if (loc_take) begin
			nxt_lvis[l_idx] = 1'b1;
		end
		if (take) begin
			nxt_vld[a_idx] = 1'b1;
			nxt_lvis[a_idx] = 1'b0;
			nxt_iss[a_idx] = 1'b0;
			nxt_dep[a_idx] = new_dep;
			nxt_waw[a_idx] = waw_vec;
			nxt_old[a_idx] = live;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vld_ff <= '0;
			lvis_ff <= '0;
			iss_ff <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				dep_ff[i] <= '0;
				waw_ff[i] <= '0;
				old_ff[i] <= '0;
			end
		end else if (i_ce) begin
			vld_ff <= nxt_vld;
			lvis_ff <= nxt_lvis;
			iss_ff <= nxt_iss;
			dep_ff <= nxt_dep;
			waw_ff <= nxt_waw;
			old_ff <= nxt_old;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				kind_ff[i] <= MOU_KIND_RST;
				addr_ff[i] <= MOU_ADDR_RST;
			end
		end else if (take) begin
			kind_ff[a_idx] <= i_op.kind;
			addr_ff[a_idx] <= i_op.addr;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= ST_IDLE;
			glob_ff <= MOU_VIS_RST;
		end else if (i_ce) begin
			case (state_ff)
				ST_IDLE: begin
					if (g_any) begin
						glob_ff <= '{kind: kind_ff[g_idx], addr: addr_ff[g_idx], tag: g_idx};
						state_ff <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (i_glob_ready) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			loc_valid_ff <= 1'b0;
			loc_ff <= MOU_VIS_RST;
			acc_valid_ff <= 1'b0;
			acc_tag_ff <= '0;
		end else if (i_ce) begin
			loc_valid_ff <= loc_take;
			acc_valid_ff <= take;
			if (loc_take) begin
				loc_ff <= '{kind: kind_ff[l_idx], addr: addr_ff[l_idx], tag: l_idx};
			end
			if (take) begin
				acc_tag_ff <= a_idx;
			end
		end
	end

	assign o_glob_valid = (state_ff == ST_BUSY);
	assign o_glob = glob_ff;
	assign o_loc_valid = loc_valid_ff;
	assign o_loc = loc_ff;
	assign o_acc_valid = acc_valid_ff;
	assign o_acc_tag = acc_tag_ff;
	assign o_empty = ~|vld_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_issue;
		issue;
	endsequence

	sequence s_issue_fence;
		issue && (kind_ff[g_idx] == K_MEMORY_FENCE_OP);
	endsequence

	property p_fence_drains;
		s_issue_fence |-> ((old_ff[g_idx] & vld_ff) == '0);
	endproperty
	a_fence_drains: assert property (p_fence_drains) else $error("fence issued with older pending");

	property p_fence_blocks;
		s_issue |-> ((old_ff[g_idx] & vld_ff & ~lvis_ff) == '0) ||
			!(|(old_ff[g_idx] & vld_ff & bar_vec & ~iss_ff));
	endproperty
	a_fence_blocks: assert property (p_fence_blocks) else $error("op passed an unissued fence");

	property p_waw_order;
		s_issue |-> ((waw_ff[g_idx] & old_ff[g_idx] & vld_ff) == '0);
	endproperty
	a_waw_order: assert property (p_waw_order) else $error("same-address write reordered");

	property p_acquire_first;
		s_issue |-> ((old_ff[g_idx] & vld_ff & bar_vec) == '0);
	endproperty
	a_acquire_first: assert property (p_acquire_first) else $error("op passed an older acquire");

	property p_release_drains;
		issue && (kind_ff[g_idx] == K_RELEASE_STORE) |-> ((old_ff[g_idx] & vld_ff) == '0);
	endproperty
	a_release_drains: assert property (p_release_drains) else $error("release passed older op");

	property p_local_first;
		s_issue |-> lvis_ff[g_idx] ##1 (o_glob_valid && o_glob.tag == $past(g_idx));
	endproperty
	a_local_first: assert property (p_local_first) else $error("global before local");

	property p_local_deps;
		loc_take |-> ((dep_ff[l_idx] & vld_ff & ~lvis_ff) == '0) ##1 o_loc_valid;
	endproperty
	a_local_deps: assert property (p_local_deps) else $error("local completion out of order");

	property p_glob_hold;
		o_glob_valid && !(i_glob_ready && i_ce) |=> o_glob_valid && $stable(o_glob);
	endproperty
	a_glob_hold: assert property (p_glob_hold) else $error("global request dropped");

	property p_retire;
		free_ev |=> !vld_ff[$past(glob_ff.tag)] && !o_glob_valid;
	endproperty
	a_retire: assert property (p_retire) else $error("entry not retired");
endmodule

// File: mou_coh_model.sv
/*
 * Coherence domain model: accepts global visibility requests after a
 * random wait, slow or prompt as the bench selects.
 * Assumes the bench seeds random numbers and drives i_slow.
 */
`timescale 1ns/1ns
module mou_coh_model (
	input wire logic i_sys_clk, // clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_slow, // long stalls
	output logic o_glob_ready // accepts request
);
	initial o_glob_ready = 1'b0;
	always @(posedge i_sys_clk) begin
		#1;
		o_glob_ready = i_arst_n && ($urandom_range(3, 0) >= (i_slow ? 3 : 1));
	end
endmodule

// File: mou_order_unit_tb_top.sv
/*
 * Bench of the memory ordering unit: issues hand-made and random op
 * groups, stamps local and global visibility, checks pairwise order.
 * Assumes each group starts with the unit empty.
 */
`timescale 1ns/1ns
module mou_order_unit_tb_top;
	import mou_pkg::*;
	logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_ce = 1'b1, i_op_valid = 1'b0, i_slow = 1'b0;
	mou_op_t i_op = '0;
	logic o_op_ready, o_acc_valid, o_loc_valid, o_glob_valid, i_glob_ready, o_empty;
	logic [MOU_TW-1:0] o_acc_tag;
	mou_vis_t o_loc, o_glob;
	mou_op_t ops [8];
	int loc_n [8], glob_n [8];
	int stamp = 0, fail_count = 0, check_count = 0, n;
	logic [MOU_TW-1:0] acc_q [$];
	logic [MOU_TW-1:0] exp_q [$];
	logic [7:0] occ = 8'h00;
	logic ce_mix = 1'b0;
	int tprog [8], ptag [8], acc_n = 0, t;
	always #4 i_sys_clk = ~i_sys_clk;
	// clock enable drops at random in mixed groups to exercise the freeze
	always @(posedge i_sys_clk) #1 i_ce = !ce_mix || ($urandom_range(3, 0) != 0);
	mou_order_unit dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
		.i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready),
		.o_acc_valid(o_acc_valid), .o_acc_tag(o_acc_tag), .o_loc_valid(o_loc_valid),
		.o_loc(o_loc), .o_glob_valid(o_glob_valid), .o_glob(o_glob),
		.i_glob_ready(i_glob_ready), .o_empty(o_empty));
	mou_coh_model coh (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_slow(i_slow),
		.o_glob_ready(i_glob_ready));
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// pulses and transfers count only at enabled edges; tags map back to program order
	always @(posedge i_sys_clk) begin
		if (i_ce === 1'b1) begin
			if (o_acc_valid === 1'b1) acc_q.push_back(o_acc_tag);
			if (o_loc_valid === 1'b1) begin
				loc_n[tprog[o_loc.tag]] = stamp;
				stamp++;
			end
			// a slot freed at this edge is not yet allocatable
			if (i_op_valid === 1'b1 && occ != 8'hFF) begin
				t = low_free(occ);
				exp_q.push_back(t[2:0]);
				tprog[t] = acc_n;
				ptag[acc_n] = t;
				occ[t] = 1'b1;
				acc_n++;
			end
			if (o_glob_valid === 1'b1 && i_glob_ready === 1'b1) begin
				check(loc_n[tprog[o_glob.tag]] >= 0, 1);
				glob_n[tprog[o_glob.tag]] = stamp;
				stamp++;
				occ[o_glob.tag] = 1'b0;
			end
		end
	end
	function automatic int low_free(input logic [7:0] m);
		for (int k = 0; k < 8; k++) begin
			if (!m[k]) return k;
		end
		return 0;
	endfunction
	function automatic logic wr(input mou_kind_t k);
		return k == K_STORE || k == K_RELEASE_STORE;
	endfunction
	task set_op(input int i, input mou_kind_t k, input int a, input int d);
		ops[i] = '{kind: k, addr: 32'h0000_1000 + a * 4, dep_valid: d >= 0, dep_tag: d[2:0]};
	endtask
	task run_group(input string name);
		int w;
		acc_q.delete();
		exp_q.delete();
		acc_n = 0;
		for (int i = 0; i < 8; i++) begin
			loc_n[i] = -1;
			glob_n[i] = -1;
		end
		for (int i = 0; i < n; i++) begin
			i_op_valid = 1'b1;
			i_op = ops[i];
			// the producer is named by the tag it was given, not its program index
			if (ops[i].dep_valid) i_op.dep_tag = ptag[ops[i].dep_tag][2:0];
			w = 0;
			do begin
				@(posedge i_sys_clk);
				w++;
			end while (!(i_ce === 1'b1 && o_op_ready === 1'b1) && w < 50);
			#1;
		end
		i_op_valid = 1'b0;
		w = 0;
		while ((acc_q.size() < n || o_empty !== 1'b1) && w < 500) begin
			@(posedge i_sys_clk) #1;
			w++;
		end
		check(o_empty, 1);
		for (int i = 0; i < n; i++) begin
			check(acc_q[i], exp_q[i]);
			for (int j = i + 1; j < n; j++) begin
				if (ops[i].kind == K_MEMORY_FENCE_OP || ops[j].kind == K_MEMORY_FENCE_OP
					|| ops[j].kind == K_RELEASE_STORE || ops[i].kind == K_ACQUIRE_LOAD)
					check(glob_n[i] < glob_n[j], 1);
				if (ops[i].addr == ops[j].addr && wr(ops[i].kind) && wr(ops[j].kind))
					check(glob_n[i] < glob_n[j], 1);
				if (ops[i].addr == ops[j].addr && (wr(ops[i].kind) || wr(ops[j].kind)))
					check(loc_n[i] < loc_n[j], 1);
				if (ops[j].dep_valid && ops[j].dep_tag == i)
					check(loc_n[i] < loc_n[j], 1);
			end
		end
		$display("test %s done", name);
	endtask
	initial begin
		#(20000 * 8);
		fail_count++;
		conclude();
	end
	initial begin
		void'($urandom(35243));
		repeat (5) @(posedge i_sys_clk);
		#1 i_arst_n = 1'b1;
		check(o_empty, 1);
		n = 3;
		set_op(0, K_STORE, 0, -1);
		set_op(1, K_MEMORY_FENCE_OP, 0, -1);
		set_op(2, K_LOAD, 1, -1);
		run_group("fence");
		set_op(0, K_STORE, 2, -1);
		set_op(1, K_RELEASE_STORE, 2, -1);
		set_op(2, K_LOAD, 2, -1);
		run_group("same address");
		set_op(0, K_ACQUIRE_LOAD, 0, -1);
		set_op(1, K_LOAD, 1, -1);
		set_op(2, K_STORE, 2, -1);
		run_group("acquire");
		set_op(0, K_LOAD, 0, -1);
		set_op(1, K_LOAD, 1, 0);
		set_op(2, K_LOAD, 2, 1);
		run_group("dependence chain");
		for (int g = 0; g < 40; g++) begin
			n = $urandom_range(8, 2);
			i_slow = g[0];
			ce_mix = g[1];
			for (int i = 0; i < n; i++)
				set_op(i, mou_kind_t'($urandom_range(4, 0)), $urandom_range(2, 0),
					(i > 0 && $urandom_range(1, 0)) ? $urandom_range(i - 1, 0) : -1);
			run_group("random");
		end
		conclude();
	end
endmodule
